// >>> io_regs_pkg.sv
// Package with offsets, field positions, reset values and carrier types of the IO register bank.
package io_regs_pkg;

  localparam logic [5:0] addr_status = 6'h00;
  localparam logic [5:0] addr_stack = 6'h02;
  localparam logic [5:0] addr_clock_mode = 6'h03;
  localparam logic [5:0] addr_int_enable = 6'h04;
  localparam logic [5:0] addr_int_request = 6'h05;
  localparam logic [5:0] addr_timer_mode = 6'h06;
  localparam logic [5:0] addr_mul_operand = 6'h08;
  localparam logic [5:0] addr_mul_high = 6'h09;
  localparam logic [5:0] addr_xtal_config = 6'h0a;
  localparam logic [5:0] addr_edge_select = 6'h0c;
  localparam logic [5:0] addr_port_a_in_enable = 6'h0d;
  localparam logic [5:0] addr_pb_in_enable = 6'h0e;
  localparam logic [5:0] addr_port_a_data = 6'h10;
  localparam logic [5:0] addr_port_a_direction = 6'h11;

  localparam logic [7:0] rst_clock_mode = 8'hf6;
  localparam logic [7:0] rst_zero = 8'h00;
  localparam logic [7:0] rst_in_enable = 8'hff;
  localparam logic [7:0] rst_stack = 8'h00;

  // Field positions.
  localparam int flag_overflow_bit = 3;
  localparam int flag_nibble_bit = 2;
  localparam int flag_carry_bit = 1;
  localparam int flag_zero_bit = 0;
  localparam int clk_fast_en_bit = 4;
  localparam int clk_type_bit = 3;
  localparam int clk_slow_en_bit = 2;
  localparam int clk_wdog_en_bit = 1;
  localparam int clk_reset_pin_bit = 0;
  localparam int edge_timer_bit = 4;
  localparam int irq_wide_timer = 2;
  localparam int irq_pin_b0_a4 = 1;
  localparam int irq_pin_a0_b5 = 0;
  localparam int xtal_en_bit = 7;
  localparam int open_drain_pin = 5;
  localparam logic [7:0] xtal_write_mask = 8'he0;
  localparam logic [7:0] edge_write_mask = 8'h1f;

  // Clock-source selections produced for the clock generator.
  typedef enum logic [3:0] {
    src_fast_div4, src_fast_div2, src_xtal_div4, src_xtal_div2, src_xtal,
    src_slow_div4, src_slow, src_fast_div16, src_fast_div8, src_slow_div16,
    src_fast_div32, src_fast_div64, src_xtal_div8, src_reserved
  } clock_select_t;

  // Register access from the core.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_access_t;

  // Flag update from the ALU; each load bit selects one flag to load.
  typedef struct packed {
    logic [3:0] load;
    logic [3:0] value;
  } flag_update_t;

endpackage : io_regs_pkg

// >>> edge_detect.sv
// Synchroniser and selectable edge detector for one pin-interrupt source.
`timescale 1ns/10ps
module edge_detect
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Pin and selection.
  input wire logic pin_in,
  input wire logic gate_in,
  input wire logic [1:0] mode_in,
  // Event.
  output logic event_out
);

  logic sync_a_reg;
  logic sync_b_reg;
  logic last_reg;

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      sync_a_reg <= pin_in;
      sync_b_reg <= sync_a_reg;
      last_reg <= sync_b_reg;
    end
  end

  // Mode 00 both edges, 01 rising, 10 falling, 11 none.
  always_comb
  begin
    case (mode_in)
      2'h0: event_out = gate_in && (sync_b_reg != last_reg);
      2'h1: event_out = gate_in && sync_b_reg && !last_reg;
      2'h2: event_out = gate_in && !sync_b_reg && last_reg;
      default: event_out = 1'b0;
    endcase
  end

endmodule : edge_detect

// >>> core_io_control_registers.sv
// Low-address IO register bank: flags, stack, clock mode, interrupts, timer mode, multiplier, ports.
`timescale 1ns/10ps
module core_io_control_registers
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Core IO access.
  input wire io_regs_pkg::io_access_t io_in,
  output logic [7:0] io_rdata_out,
  // ALU flag updates and multiplier.
  input wire io_regs_pkg::flag_update_t flag_upd_in,
  input wire logic mul_in,
  input wire logic [7:0] acc_in,
  output logic [7:0] mul_low_out,
  // Peripheral interrupt events (timer three, timer two, pwm, comparator, adc).
  input wire logic [7:3] periph_event_in,
  input wire logic [15:0] wide_timer_count_in,
  // Port pins.
  input wire logic [7:0] port_a_pin_in,
  input wire logic [7:0] pb_pin_in,
  output logic [7:0] port_a_pin_out,
  output logic [7:0] port_a_pin_oe_out,
  output logic [7:0] port_a_digital_in_out,
  output logic [7:0] pb_digital_in_out,
  output logic [7:0] port_a_wake_en_out,
  output logic [7:0] pb_wake_en_out,
  // Clock and system control.
  output io_regs_pkg::clock_select_t clock_select_out,
  output logic fast_osc_en_out,
  output logic slow_osc_en_out,
  output logic watchdog_en_out,
  output logic external_reset_pin_en_out,
  output logic crystal_osc_en_out,
  output logic [1:0] crystal_drive_out,
  output logic [2:0] wide_timer_clock_sel_out,
  output logic [1:0] wide_timer_prescale_out,
  output logic [7:0] stack_pointer_out,
  output logic [3:0] flags_out,
  output logic irq_pending_out
);
  import io_regs_pkg::*;

  logic [3:0] flags_reg;
  logic [7:0] stack_reg;
  logic [7:0] clock_mode_reg;
  logic [7:0] int_enable_reg;
  logic [7:0] int_request_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] mul_operand_reg;
  logic [7:0] mul_high_reg;
  logic [7:0] xtal_config_reg;
  logic [7:0] edge_select_reg;
  logic [7:0] port_a_in_enable_reg;
  logic [7:0] pb_in_enable_reg;
  logic [7:0] port_a_data_reg;
  logic [7:0] port_a_direction_reg;
  logic [7:0] mul_low_reg;
  logic timer_bit_last_reg;
  logic [7:0] int_request_next;
  logic [7:0] hw_event;
  logic [15:0] product;
  logic timer_bit;
  logic pin_ev_b0;
  logic pin_ev_a4;
  logic pin_ev_a0;
  logic pin_ev_b5;
  logic wr_hit;

  assign wr_hit = io_in.wr;

  // ==========================================================================
  // ALU status flags.
  // ==========================================================================
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      flags_reg <= rst_zero[3:0];
    else if (wr_hit && io_in.addr == addr_status)
      flags_reg <= io_in.wdata[3:0];
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        // Bit 3 overflow, 2 nibble carry, 1 carry, 0 zero.
        if (flag_upd_in.load[i])
          flags_reg[i] <= flag_upd_in.value[i];
      end
    end
  end

  // ==========================================================================
  // Stack pointer, written as given; bit 0 is software's to keep clear.
  // ==========================================================================
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      stack_reg <= rst_stack;
    else if (wr_hit && io_in.addr == addr_stack)
      stack_reg <= io_in.wdata;
  end

  // ==========================================================================
  // Configuration registers.
  // ==========================================================================
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      clock_mode_reg <= rst_clock_mode;
      int_enable_reg <= rst_zero;
      timer_mode_reg <= rst_zero;
      xtal_config_reg <= rst_zero;
      edge_select_reg <= rst_zero;
      port_a_in_enable_reg <= rst_in_enable;
      pb_in_enable_reg <= rst_in_enable;
      port_a_data_reg <= rst_zero;
      port_a_direction_reg <= rst_zero;
      mul_operand_reg <= rst_zero;
    end
    else if (wr_hit)
    begin
      if (io_in.addr == addr_clock_mode)
        clock_mode_reg <= io_in.wdata;
      else if (io_in.addr == addr_int_enable)
        int_enable_reg <= io_in.wdata;
      else if (io_in.addr == addr_timer_mode)
        timer_mode_reg <= io_in.wdata;
      else if (io_in.addr == addr_mul_operand)
        mul_operand_reg <= io_in.wdata;
      else if (io_in.addr == addr_xtal_config)
        xtal_config_reg <= io_in.wdata & xtal_write_mask;
      else if (io_in.addr == addr_edge_select)
        edge_select_reg <= io_in.wdata & edge_write_mask;
      else if (io_in.addr == addr_port_a_in_enable)
        port_a_in_enable_reg <= io_in.wdata;
      else if (io_in.addr == addr_pb_in_enable)
        pb_in_enable_reg <= io_in.wdata;
      else if (io_in.addr == addr_port_a_data)
        port_a_data_reg <= io_in.wdata;
      else if (io_in.addr == addr_port_a_direction)
        port_a_direction_reg <= io_in.wdata;
    end
  end

  // ==========================================================================
  // Multiplier.
  // ==========================================================================
  assign product = acc_in * mul_operand_reg;

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      mul_high_reg <= rst_zero;
      mul_low_reg <= rst_zero;
    end
    else if (mul_in)
    begin
      mul_high_reg <= product[15:8];
      mul_low_reg <= product[7:0];
    end
  end

  assign mul_low_out = mul_low_reg;

  // ==========================================================================
  // Interrupt sources.
  // ==========================================================================
  // Counter bit 8 + code, compared with its previous value.
  assign timer_bit = wide_timer_count_in[4'(8 + timer_mode_reg[2:0])];

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      timer_bit_last_reg <= 1'b0;
    else
      timer_bit_last_reg <= timer_bit;
  end

  edge_detect u_edge_b0
  (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .pin_in(pb_pin_in[0]),
    .gate_in(pb_in_enable_reg[0]),
    .mode_in(edge_select_reg[3:2]),
    .event_out(pin_ev_b0)
  );

  edge_detect u_edge_a4
  (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .pin_in(port_a_pin_in[4]),
    .gate_in(port_a_in_enable_reg[4]),
    .mode_in(edge_select_reg[3:2]),
    .event_out(pin_ev_a4)
  );

  edge_detect u_edge_a0
  (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .pin_in(port_a_pin_in[0]),
    .gate_in(port_a_in_enable_reg[0]),
    .mode_in(edge_select_reg[1:0]),
    .event_out(pin_ev_a0)
  );

  edge_detect u_edge_b5
  (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .pin_in(pb_pin_in[5]),
    .gate_in(pb_in_enable_reg[5]),
    .mode_in(edge_select_reg[1:0]),
    .event_out(pin_ev_b5)
  );

  always_comb
  begin
    hw_event = {periph_event_in, 3'h0};
    // Rising when edge bit is zero, falling when one.
    hw_event[irq_wide_timer] = edge_select_reg[edge_timer_bit] ?
                               (timer_bit_last_reg && !timer_bit) :
                               (!timer_bit_last_reg && timer_bit);
    hw_event[irq_pin_b0_a4] = pin_ev_b0 || pin_ev_a4;
    hw_event[irq_pin_a0_b5] = pin_ev_a0 || pin_ev_b5;
  end

  // Software writes load the register; a same-cycle event still sets its bit.
  always_comb
  begin
    int_request_next = int_request_reg;
    if (wr_hit && io_in.addr == addr_int_request)
      int_request_next = io_in.wdata;
    int_request_next = int_request_next | hw_event;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      int_request_reg <= rst_zero;
    else
      int_request_reg <= int_request_next;
  end

  assign irq_pending_out = |(int_request_reg & int_enable_reg);

  // ==========================================================================
  // Clock selection.
  // ==========================================================================
  always_comb
  begin
    if (clock_mode_reg[clk_type_bit])
    begin
      case (clock_mode_reg[7:5])
        3'h0: clock_select_out = src_fast_div16;
        3'h1: clock_select_out = src_fast_div8;
        3'h2: clock_select_out = src_slow_div16;
        3'h3: clock_select_out = src_fast_div32;
        3'h4: clock_select_out = src_fast_div64;
        3'h5: clock_select_out = src_xtal_div8;
        default: clock_select_out = src_reserved;
      endcase
    end
    else
    begin
      case (clock_mode_reg[7:5])
        3'h0: clock_select_out = src_fast_div4;
        3'h1: clock_select_out = src_fast_div2;
        3'h3: clock_select_out = src_xtal_div4;
        3'h4: clock_select_out = src_xtal_div2;
        3'h5: clock_select_out = src_xtal;
        3'h6: clock_select_out = src_slow_div4;
        3'h7: clock_select_out = src_slow;
        default: clock_select_out = src_reserved;
      endcase
    end
  end

  assign fast_osc_en_out = clock_mode_reg[clk_fast_en_bit];
  assign slow_osc_en_out = clock_mode_reg[clk_slow_en_bit];
  // The watchdog runs from the slow oscillator, so it stops with it.
  assign watchdog_en_out = clock_mode_reg[clk_wdog_en_bit] &&
                           clock_mode_reg[clk_slow_en_bit];
  assign external_reset_pin_en_out = clock_mode_reg[clk_reset_pin_bit];
  assign crystal_osc_en_out = xtal_config_reg[xtal_en_bit];
  assign crystal_drive_out = xtal_config_reg[6:5];
  assign wide_timer_clock_sel_out = timer_mode_reg[7:5];
  assign wide_timer_prescale_out = timer_mode_reg[4:3];
  assign stack_pointer_out = stack_reg;
  assign flags_out = flags_reg;

  // ==========================================================================
  // Port A pins and input gating.
  // ==========================================================================
  for (genvar p = 0; p < 8; p++)
  begin : g_port_a
    if (p == open_drain_pin)
    begin : g_od
      // Drives low only; as reset input it never drives.
      assign port_a_pin_out[p] = 1'b0;
      assign port_a_pin_oe_out[p] = port_a_direction_reg[p] && !port_a_data_reg[p] &&
                                    !clock_mode_reg[clk_reset_pin_bit];
    end
    else
    begin : g_pp
      assign port_a_pin_out[p] = port_a_data_reg[p];
      assign port_a_pin_oe_out[p] = port_a_direction_reg[p];
    end
  end

  assign port_a_digital_in_out = port_a_in_enable_reg;
  assign port_a_wake_en_out = port_a_in_enable_reg;
  assign pb_digital_in_out = pb_in_enable_reg;
  assign pb_wake_en_out = pb_in_enable_reg;

  // ==========================================================================
  // Read path; write-only and unmapped addresses read zero.
  // ==========================================================================
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
      io_rdata_out <= rst_zero;
    else if (io_in.rd)
    begin
      if (io_in.addr == addr_status)
        io_rdata_out <= {4'h0, flags_reg};
      else if (io_in.addr == addr_stack)
        io_rdata_out <= stack_reg;
      else if (io_in.addr == addr_clock_mode)
        io_rdata_out <= clock_mode_reg;
      else if (io_in.addr == addr_int_enable)
        io_rdata_out <= int_enable_reg;
      else if (io_in.addr == addr_int_request)
        io_rdata_out <= int_request_reg;
      else if (io_in.addr == addr_timer_mode)
        io_rdata_out <= timer_mode_reg;
      else if (io_in.addr == addr_mul_operand)
        io_rdata_out <= mul_operand_reg;
      else if (io_in.addr == addr_mul_high)
        io_rdata_out <= mul_high_reg;
      else if (io_in.addr == addr_port_a_data)
        io_rdata_out <= port_a_data_reg;
      else if (io_in.addr == addr_port_a_direction)
        io_rdata_out <= port_a_direction_reg;
      else
        io_rdata_out <= rst_zero;
    end
  end

endmodule : core_io_control_registers

// >>> core_io_monitor.sv
// Checker of port relations of the IO register bank.
`timescale 1ns/10ps
module core_io_monitor
  import io_regs_pkg::*;
(
  // Clock, reset and core side.
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire io_regs_pkg::io_access_t io_in,
  input wire io_regs_pkg::flag_update_t flag_upd_in,
  input wire logic mul_in,
  // Observed outputs.
  input wire logic [7:0] io_rdata_out,
  input wire logic [7:0] mul_low_out,
  input wire logic [3:0] flags_out,
  input wire logic fast_osc_en_out,
  input wire logic slow_osc_en_out,
  input wire logic watchdog_en_out,
  input wire logic external_reset_pin_en_out,
  input wire logic crystal_osc_en_out,
  input wire logic [1:0] crystal_drive_out,
  input wire logic [2:0] wide_timer_clock_sel_out,
  input wire logic [1:0] wide_timer_prescale_out,
  input wire logic [7:0] port_a_pin_out,
  input wire logic [7:0] port_a_pin_oe_out
);
  // ==========================================================
  // Helper logic
  logic [7:0] pw;
  logic [5:0] a;
  logic st_wr;
  assign a = io_in.addr;
  assign st_wr = io_in.wr && a == 6'h00;
  // Write data of the previous cycle.
  always_ff @(posedge mclk_in)
  begin
    pw <= io_in.wdata;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  // ==========================================================
  // Assertions
  a_flag_load_hold: assert property (!st_wr |=>
    ((((flags_out ^ $past(flag_upd_in.value)) & $past(flag_upd_in.load))
    | ((flags_out ^ $past(flags_out)) & ~$past(flag_upd_in.load))) == 4'h0))
    else $error("flag load or hold wrong");
  a_flag_write_wins: assert property (st_wr |=> flags_out == pw[3:0])
    else $error("flag write lost");
  a_watchdog_slow_osc: assert property (watchdog_en_out |-> slow_osc_en_out)
    else $error("watchdog runs without slow osc");
  a_clock_mode_write: assert property (io_in.wr && a == 6'h03 |=>
    {fast_osc_en_out, slow_osc_en_out, watchdog_en_out, external_reset_pin_en_out}
    == {pw[4], pw[2], pw[2] & pw[1], pw[0]})
    else $error("clock mode enables wrong");
  a_xtal_cfg_write: assert property (io_in.wr && a == 6'h0a |=>
    {crystal_osc_en_out, crystal_drive_out} == pw[7:5])
    else $error("crystal config wrong");
  a_timer_mode_write: assert property (io_in.wr && a == 6'h06 |=>
    {wide_timer_clock_sel_out, wide_timer_prescale_out} == pw[7:3])
    else $error("timer mode wrong");
  a_bit5_open_drain: assert property (port_a_pin_oe_out[5] |->
    !port_a_pin_out[5] && !external_reset_pin_en_out)
    else $error("port a bit 5 driven high");
  a_mul_low_hold: assert property (!mul_in |=> $stable(mul_low_out))
    else $error("low product changed without multiply");
  a_wo_read_zero: assert property (io_in.rd && a inside {6'h0a, 6'h0c, 6'h0d, 6'h0e}
    |=> io_rdata_out == 8'h00)
    else $error("write-only register read nonzero");
  a_port_dir_drive: assert property (io_in.wr && a == 6'h11 |=>
    (port_a_pin_oe_out & 8'hdf) == (pw & 8'hdf))
    else $error("port a direction wrong");
endmodule : core_io_monitor

bind core_io_control_registers core_io_monitor u_core_io_monitor (.mclk_in(mclk_in),
  .reset_n_in(reset_n_in), .io_in(io_in), .flag_upd_in(flag_upd_in), .mul_in(mul_in),
  .io_rdata_out(io_rdata_out), .mul_low_out(mul_low_out), .flags_out(flags_out),
  .fast_osc_en_out(fast_osc_en_out), .slow_osc_en_out(slow_osc_en_out),
  .watchdog_en_out(watchdog_en_out), .external_reset_pin_en_out(external_reset_pin_en_out),
  .crystal_osc_en_out(crystal_osc_en_out), .crystal_drive_out(crystal_drive_out),
  .wide_timer_clock_sel_out(wide_timer_clock_sel_out),
  .wide_timer_prescale_out(wide_timer_prescale_out), .port_a_pin_out(port_a_pin_out),
  .port_a_pin_oe_out(port_a_pin_oe_out));

// >>> core_io_control_registers_bench.sv
// Self-checking bench of the IO register bank.
`timescale 1ns/10ps
module core_io_control_registers_bench;
  import io_regs_pkg::*;
  // ==========================================================
  // Signals
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  io_access_t io_in = '0;
  flag_update_t flag_upd_in = '0;
  logic mul_in = 1'b0;
  logic [7:0] acc_in = 8'h00;
  logic [7:3] periph_event_in = '0;
  logic [15:0] wide_timer_count_in = 16'h0000;
  logic [7:0] port_a_pin_in = 8'h00;
  logic [7:0] pb_pin_in = 8'h00;
  logic [7:0] io_rdata_out, mul_low_out, port_a_pin_out, port_a_pin_oe_out, stack_pointer_out;
  logic [7:0] port_a_digital_in_out, pb_digital_in_out, port_a_wake_en_out, pb_wake_en_out;
  clock_select_t clock_select_out;
  logic fast_osc_en_out, slow_osc_en_out, watchdog_en_out, external_reset_pin_en_out;
  logic crystal_osc_en_out, irq_pending_out;
  logic [1:0] crystal_drive_out, wide_timer_prescale_out;
  logic [2:0] wide_timer_clock_sel_out;
  logic [3:0] flags_out;
  logic [7:0] d, e, f;
  logic [15:0] prod;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  clock_select_t t0 [8] = '{src_fast_div4, src_fast_div2, src_reserved, src_xtal_div4,
    src_xtal_div2, src_xtal, src_slow_div4, src_slow};
  clock_select_t t1 [8] = '{src_fast_div16, src_fast_div8, src_slow_div16, src_fast_div32,
    src_fast_div64, src_xtal_div8, src_reserved, src_reserved};

  core_io_control_registers u_core_io_control_registers (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .io_in(io_in), .io_rdata_out(io_rdata_out),
    .flag_upd_in(flag_upd_in), .mul_in(mul_in), .acc_in(acc_in), .mul_low_out(mul_low_out),
    .periph_event_in(periph_event_in), .wide_timer_count_in(wide_timer_count_in),
    .port_a_pin_in(port_a_pin_in), .pb_pin_in(pb_pin_in), .port_a_pin_out(port_a_pin_out),
    .port_a_pin_oe_out(port_a_pin_oe_out), .port_a_digital_in_out(port_a_digital_in_out),
    .pb_digital_in_out(pb_digital_in_out), .port_a_wake_en_out(port_a_wake_en_out),
    .pb_wake_en_out(pb_wake_en_out), .clock_select_out(clock_select_out),
    .fast_osc_en_out(fast_osc_en_out), .slow_osc_en_out(slow_osc_en_out),
    .watchdog_en_out(watchdog_en_out), .external_reset_pin_en_out(external_reset_pin_en_out),
    .crystal_osc_en_out(crystal_osc_en_out), .crystal_drive_out(crystal_drive_out),
    .wide_timer_clock_sel_out(wide_timer_clock_sel_out),
    .wide_timer_prescale_out(wide_timer_prescale_out), .stack_pointer_out(stack_pointer_out),
    .flags_out(flags_out), .irq_pending_out(irq_pending_out));

  always #12.5 mclk_in = ~mclk_in;

  // ==========================================================
  // Tasks
  task finish_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task chk(input string n, input logic [7:0] ex, input logic [7:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask : chk

  // Bit 5 only sinks, so it stops driving when its data bit is one.
  function automatic logic [7:0] exp_oe(input logic [7:0] dir, input logic [7:0] dat);
    exp_oe = dir & ~(dat & 8'h20);
  endfunction : exp_oe

  // Each loaded flag takes its new value, the others hold.
  function automatic logic [3:0] exp_flags(input logic [3:0] old, input flag_update_t upd);
    exp_flags = (old & ~upd.load) | (upd.value & upd.load);
  endfunction : exp_flags

  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    io_in <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge mclk_in);
    io_in <= '0;
    #1;
  endtask : wr

  task rd(input logic [5:0] a, input logic [7:0] ex);
    @(posedge mclk_in);
    io_in <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk_in);
    io_in <= '0;
    #1;
    chk("io_rdata_out", ex, io_rdata_out);
  endtask : rd

  // Moves pin k (0 port A bit 0, 1 port B bit 0) and checks the request register.
  task pin_step(input logic k, input logic lv, input logic [7:0] ex);
    @(posedge mclk_in);
    port_a_pin_in <= {7'h00, lv & ~k};
    pb_pin_in <= {7'h00, lv & k};
    repeat (5) @(posedge mclk_in);
    rd(addr_int_request, ex);
    wr(addr_int_request, 8'h00);
  endtask : pin_step

  // The run should need a few thousand cycles at most.
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h28421332));
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd(addr_status, 8'h00);
    rd(addr_clock_mode, 8'hf6);
    rd(addr_int_enable, 8'h00);
    rd(addr_timer_mode, 8'h00);
    rd(addr_port_a_direction, 8'h00);
    rd(addr_port_a_data, 8'h00);
    chk("clock_select_out", src_slow, clock_select_out);
    chk("port_a_digital_in_out", 8'hff, port_a_digital_in_out);
    chk("pb_digital_in_out", 8'hff, pb_digital_in_out);
    for (int i = 0; i < 16; i++)
    begin
      wr(addr_clock_mode, {i[2:0], 1'b1, i[3], 3'b110});
      d = 8'(i[3] ? t1[i[2:0]] : t0[i[2:0]]);
      chk("clock_select_out", d, clock_select_out);
    end
    wr(addr_clock_mode, 8'he3);
    chk("clock_enables", 8'h01, {fast_osc_en_out, slow_osc_en_out, watchdog_en_out,
      external_reset_pin_en_out});
    wr(addr_port_a_direction, 8'hff);
    wr(addr_port_a_data, 8'h00);
    chk("port_a_pin_oe_out", 8'hdf, port_a_pin_oe_out);
    wr(addr_clock_mode, 8'hf6);
    chk("port_a_pin_oe_out", 8'hff, port_a_pin_oe_out);
    for (int i = 0; i < 5; i++)
    begin
      d = i == 0 ? 8'hff : 8'($urandom);
      f = i == 0 ? 8'hff : 8'($urandom);
      wr(addr_port_a_direction, d);
      wr(addr_port_a_data, f);
      chk("port_a_pin_oe_out", exp_oe(d, f), port_a_pin_oe_out);
      chk("port_a_pin_out", f & 8'hdf, port_a_pin_out);
      rd(addr_port_a_direction, d);
      rd(addr_port_a_data, f);
    end
    e = 8'h00;
    repeat (6)
    begin
      d = 8'($urandom);
      f = 8'($urandom);
      @(posedge mclk_in);
      flag_upd_in <= {d[3:0], f[3:0]};
      @(posedge mclk_in);
      flag_upd_in <= '0;
      e[3:0] = exp_flags(e[3:0], {d[3:0], f[3:0]});
      rd(addr_status, e);
    end
    f = 8'($urandom);
    @(posedge mclk_in);
    io_in <= '{rd: 1'b0, wr: 1'b1, addr: addr_status, wdata: f};
    flag_upd_in <= {4'hf, ~f[3:0]};
    @(posedge mclk_in);
    io_in <= '0;
    flag_upd_in <= '0;
    #1;
    chk("flags_out", f[3:0], flags_out);
    d = 8'($urandom) & 8'hfe;
    wr(addr_stack, d);
    rd(addr_stack, d);
    chk("stack_pointer_out", d, stack_pointer_out);
    for (int i = 0; i < 5; i++)
    begin
      d = i == 0 ? 8'hff : 8'($urandom);
      f = i == 0 ? 8'hff : 8'($urandom);
      prod = d * f;
      wr(addr_mul_operand, d);
      @(posedge mclk_in);
      mul_in <= 1'b1;
      acc_in <= f;
      @(posedge mclk_in);
      mul_in <= 1'b0;
      #1;
      chk("mul_low_out", prod[7:0], mul_low_out);
      rd(addr_mul_high, prod[15:8]);
      rd(addr_mul_operand, d);
      wr(addr_mul_high, ~prod[15:8]);
      rd(addr_mul_high, prod[15:8]);
    end
    repeat (4)
    begin
      d = 8'($urandom);
      f = 8'($urandom) & 8'hf8;
      wr(addr_int_enable, d);
      wr(addr_int_request, 8'h00);
      @(posedge mclk_in);
      periph_event_in <= f[7:3];
      @(posedge mclk_in);
      periph_event_in <= '0;
      rd(addr_int_request, f);
      chk("irq_pending_out", 8'(|(d & f)), irq_pending_out);
      rd(addr_int_enable, d);
      wr(addr_int_request, 8'h00);
      rd(addr_int_request, 8'h00);
    end
    // A clear written in the cycle of an event leaves the event's bit set.
    @(posedge mclk_in);
    io_in <= '{rd: 1'b0, wr: 1'b1, addr: addr_int_request, wdata: 8'h00};
    periph_event_in <= 5'h10;
    @(posedge mclk_in);
    io_in <= '0;
    periph_event_in <= '0;
    rd(addr_int_request, 8'h80);
    wr(addr_int_request, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      e = 8'($urandom) & 8'h10;
      wr(addr_timer_mode, {8'($urandom) & 8'hf8} | 8'(c));
      wr(addr_edge_select, e);
      @(posedge mclk_in);
      wide_timer_count_in <= 16'($urandom_range(255)) | (16'h0100 << c);
      repeat (3) @(posedge mclk_in);
      rd(addr_int_request, e[4] ? 8'h00 : 8'h04);
      wr(addr_int_request, 8'h00);
      @(posedge mclk_in);
      wide_timer_count_in <= 16'($urandom_range(255));
      repeat (3) @(posedge mclk_in);
      rd(addr_int_request, e[4] ? 8'h04 : 8'h00);
      wr(addr_int_request, 8'h00);
    end
    for (int k = 0; k < 2; k++)
    begin
      for (int m = 0; m < 3; m++)
      begin
        wr(addr_edge_select, 8'(m * 5));
        pin_step(k[0], 1'b1, (m != 2) ? 8'(k + 1) : 8'h00);
        pin_step(k[0], 1'b0, (m != 1) ? 8'(k + 1) : 8'h00);
      end
    end
    // Both edges again, so only the cleared enable can hold the request back.
    wr(addr_edge_select, 8'h00);
    wr(addr_pb_in_enable, 8'hfe);
    chk("pb_wake_en_out", 8'hfe, pb_wake_en_out);
    pin_step(1'b1, 1'b1, 8'h00);
    wr(addr_port_a_in_enable, 8'h3e);
    chk("port_a_wake_en_out", 8'h3e, port_a_wake_en_out);
    pin_step(1'b0, 1'b1, 8'h00);
    rd(addr_port_a_in_enable, 8'h00);
    d = 8'($urandom);
    wr(addr_xtal_config, d);
    chk("crystal", {5'h00, d[7:5]}, {crystal_osc_en_out, crystal_drive_out});
    rd(addr_xtal_config, 8'h00);
    rd(addr_edge_select, 8'h00);
    wr(6'h3f, 8'($urandom));
    rd(6'h3f, 8'h00);
    finish_test();
  end
endmodule : core_io_control_registers_bench
